// [qsh_consts.svh]
// Constants for the quick stop and halt sequencer
// Overview of operation
// RULE1 - Option 6: quick stop ramp, stay active, servo on
// RULE2 - Torque modes: immediate disable, dynamic brake stop
// RULE3 - Option 1: mode ramp, then switch-on disabled
// RULE4 - Option 2: quick stop ramp, then switch-on disabled
// RULE5 - Option 5: mode ramp, stay active, servo on
// RULE6 - Controller cancels csp stop only after follow-up
// RULE7 - Controller without follow-up avoids options 5, 6
// RULE8 - Halt bit: halt ramp, stay operation enabled
// RULE9 - Halt cleared mid-ramp: finish stop, resume
// RULE10 - Halt acts only in pp, pv, tq, pt, jog, homing
// RULE11 - Halt in tq forces torque demand to zero
// RULE12 - Tq halt torque ramp follows torque slope
// RULE13 - Point table halt uses point table deceleration
// RULE14 - Unsupported option writes refused, old value kept
`ifndef QSH_CONSTS_SVH
`define QSH_CONSTS_SVH
`define OPT_W 16
`define QS_OPT_RAMP_MODE_DIS 16'h0001
`define QS_OPT_RAMP_QS_DIS 16'h0002
`define QS_OPT_RAMP_MODE_HOLD 16'h0005
`define QS_OPT_RAMP_QS_HOLD 16'h0006
`define HALT_OPT_RAMP_MODE 16'h0001
`define QS_OPT_RESET 16'h0002
`define HALT_OPT_RESET 16'h0001
`endif

// [qsh_pkg.sv]
// Types shared by the quick stop and halt sequencer
package qsh_pkg;
    typedef enum logic [3:0] {
        MODE_NONE = 4'h0,
        MODE_PP = 4'h1,
        MODE_PV = 4'h2,
        MODE_TQ = 4'h3,
        MODE_HM = 4'h4,
        MODE_CSP = 4'h5,
        MODE_CSV = 4'h6,
        MODE_CST = 4'h7,
        MODE_POINT_TABLE = 4'h8,
        MODE_JOG = 4'h9,
        MODE_CONT_TORQUE = 4'hA
    } ctrl_mode_t;
    typedef enum logic [5:0] {
        ST_SW_ON_DIS = 6'h01,
        ST_OP_EN = 6'h02,
        ST_QS_DECEL = 6'h04,
        ST_QS_ACTIVE = 6'h08,
        ST_HALT_DECEL = 6'h10,
        ST_HALT_HOLD = 6'h20
    } drive_state_t;
    typedef enum logic [2:0] {
        SRC_NONE = 3'h0,
        SRC_QS_DECEL = 3'h1,
        SRC_PROFILE_DECEL = 3'h2,
        SRC_HOMING_ACCEL = 3'h3,
        SRC_POINT_TABLE_DECEL = 3'h4,
        SRC_TORQUE_SLOPE = 3'h5
    } decel_src_t;
endpackage

// [opt_code_reg.sv]
// Option code holding register that refuses unsupported values
`timescale 1ns/1ps
`default_nettype none
module opt_code_reg #(
    parameter int W = 16,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    input wire logic i_clk, // System clock
    input wire logic i_sys_rst, // Synchronous reset
    input wire logic i_wr, // Write strobe
    input wire logic [W-1:0] i_val, // Written value
    input wire logic i_supported, // Written value is supported
    output logic [W-1:0] o_val, // Accepted option code
    output logic o_reject // Pulse: write refused
);
    logic [W-1:0] val_q;
    logic rej_q;

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            val_q <= RESET_VAL;
            rej_q <= 1'b0;
        end else begin
            if (i_wr && i_supported) begin
                val_q <= i_val; // see RULE14
            end
            rej_q <= i_wr && !i_supported;
        end
    end

    assign o_val = val_q;
    assign o_reject = rej_q;
endmodule
`default_nettype wire

// [quick_stop_halt_sequencer.sv]
// Quick stop and halt sequencing for the drive state machine
`timescale 1ns/1ps
`default_nettype none
`include "qsh_consts.svh"
module quick_stop_halt_sequencer #(
    parameter int OPT_W = `OPT_W
) (
    input wire logic i_clk, // System clock, 50 MHz
    input wire logic i_sys_rst, // Synchronous reset, active high
    input wire qsh_pkg::ctrl_mode_t i_mode, // Active control mode
    input wire logic i_enable_cmd, // Enable operation commanded
    input wire logic i_qs_cmd, // Quick stop commanded, level
    input wire logic i_halt_bit, // Controlword halt bit
    input wire logic i_at_standstill, // Motor has stopped
    input wire logic i_qs_opt_wr, // Quick stop option write strobe
    input wire logic [OPT_W-1:0] i_qs_opt_val, // Quick stop option write value
    input wire logic i_halt_opt_wr, // Halt option write strobe
    input wire logic [OPT_W-1:0] i_halt_opt_val, // Halt option write value
    output qsh_pkg::drive_state_t o_state, // One-hot drive state
    output logic o_servo_on, // Servo power stage on
    output logic o_dyn_brake, // Dynamic brake engaged
    output qsh_pkg::decel_src_t o_decel_src, // Deceleration source in use
    output logic o_torque_zero, // Force torque demand to zero
    output logic [OPT_W-1:0] o_qs_opt, // Accepted quick stop option
    output logic [OPT_W-1:0] o_halt_opt, // Accepted halt option
    output logic o_opt_reject // Pulse: option write refused
);
    import qsh_pkg::*;

    if (OPT_W < 4) begin : g_width_check
        $error("OPT_W too narrow for option codes");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Option code registers

    logic qs_opt_ok;
    logic halt_opt_ok;
    logic qs_rej;
    logic halt_rej;
    logic [OPT_W-1:0] qs_opt;
    logic [OPT_W-1:0] halt_opt;

    // Only the ramp codes the sequencer can carry out are accepted
    assign qs_opt_ok = (i_qs_opt_val == OPT_W'(`QS_OPT_RAMP_MODE_DIS))
        || (i_qs_opt_val == OPT_W'(`QS_OPT_RAMP_QS_DIS))
        || (i_qs_opt_val == OPT_W'(`QS_OPT_RAMP_MODE_HOLD))
        || (i_qs_opt_val == OPT_W'(`QS_OPT_RAMP_QS_HOLD)); // see RULE14
    assign halt_opt_ok = (i_halt_opt_val == OPT_W'(`HALT_OPT_RAMP_MODE));

    opt_code_reg #(
        .W(OPT_W),
        .RESET_VAL(OPT_W'(`QS_OPT_RESET))
    ) u_qs_opt (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_wr(i_qs_opt_wr),
        .i_val(i_qs_opt_val),
        .i_supported(qs_opt_ok),
        .o_val(qs_opt),
        .o_reject(qs_rej)
    );

    opt_code_reg #(
        .W(OPT_W),
        .RESET_VAL(OPT_W'(`HALT_OPT_RESET))
    ) u_halt_opt (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_wr(i_halt_opt_wr),
        .i_val(i_halt_opt_val),
        .i_supported(halt_opt_ok),
        .o_val(halt_opt),
        .o_reject(halt_rej)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Mode classification and deceleration source selection

    logic torque_mode;
    logic halt_mode;
    logic opt_uses_qs_ramp;
    logic opt_keeps_servo;
    decel_src_t mode_src;
    decel_src_t qs_src;
    decel_src_t halt_src;

    assign torque_mode = (i_mode == MODE_CST) || (i_mode == MODE_TQ)
        || (i_mode == MODE_CONT_TORQUE);
    assign halt_mode = (i_mode == MODE_PP) || (i_mode == MODE_PV) || (i_mode == MODE_TQ)
        || (i_mode == MODE_POINT_TABLE) || (i_mode == MODE_JOG)
        || (i_mode == MODE_HM); // see RULE10
    assign opt_uses_qs_ramp = (qs_opt == OPT_W'(`QS_OPT_RAMP_QS_DIS))
        || (qs_opt == OPT_W'(`QS_OPT_RAMP_QS_HOLD));
    assign opt_keeps_servo = (qs_opt == OPT_W'(`QS_OPT_RAMP_MODE_HOLD))
        || (qs_opt == OPT_W'(`QS_OPT_RAMP_QS_HOLD)); // see RULE1 see RULE5

    // Mode's own ramp; csp and csv have none and fall back to the quick stop ramp
    assign mode_src = (i_mode == MODE_PP || i_mode == MODE_PV || i_mode == MODE_JOG)
        ? SRC_PROFILE_DECEL
        : (i_mode == MODE_HM) ? SRC_HOMING_ACCEL
        : (i_mode == MODE_POINT_TABLE) ? SRC_POINT_TABLE_DECEL
        : (i_mode == MODE_CSP || i_mode == MODE_CSV) ? SRC_QS_DECEL
        : SRC_NONE; // see RULE3 see RULE5
    assign qs_src = opt_uses_qs_ramp ? SRC_QS_DECEL : mode_src; // see RULE4 see RULE1
    // Torque halt ignores the halt option and ramps torque by its slope
    assign halt_src = (i_mode == MODE_TQ) ? SRC_TORQUE_SLOPE
        : mode_src; // see RULE8 see RULE11 see RULE12 see RULE13

    ////////////////////////////////////////////////////////////////////////////
    // Drive state sequencing

    drive_state_t state_q;
    drive_state_t state_d;
    decel_src_t src_q;
    decel_src_t src_d;
    logic servo_q;
    logic brake_q;
    logic brake_d;
    logic tzero_q;
    logic rej_q;
    logic qs_entry;
    logic qs_brake_entry;

    assign qs_entry = i_qs_cmd && ((state_q == ST_OP_EN) || (state_q == ST_HALT_DECEL)
        || (state_q == ST_HALT_HOLD));
    // A dropped enable outranks the quick stop and leaves the brake off
    assign qs_brake_entry = qs_entry && torque_mode && i_enable_cmd; // see RULE2

    always_comb begin
        state_d = state_q;
        src_d = src_q;
        case (state_q)
            ST_SW_ON_DIS: begin
                src_d = SRC_NONE;
                if (i_enable_cmd && !i_qs_cmd) begin
                    state_d = ST_OP_EN;
                end
            end
            ST_OP_EN, ST_HALT_DECEL, ST_HALT_HOLD: begin
                if (!i_enable_cmd) begin
                    state_d = ST_SW_ON_DIS;
                    src_d = SRC_NONE;
                end else if (qs_brake_entry) begin
                    state_d = ST_SW_ON_DIS; // see RULE2
                    src_d = SRC_NONE;
                end else if (qs_entry) begin
                    state_d = ST_QS_DECEL;
                    src_d = qs_src; // see RULE1 see RULE3 see RULE4 see RULE5
                end else if (state_q == ST_OP_EN) begin
                    if (i_halt_bit && halt_mode) begin
                        state_d = ST_HALT_DECEL; // see RULE8 see RULE10
                        src_d = halt_src;
                    end
                end else if (state_q == ST_HALT_DECEL) begin
                    // A halt released mid-ramp still finishes the stop
                    if (i_at_standstill) begin
                        state_d = i_halt_bit ? ST_HALT_HOLD : ST_OP_EN; // see RULE9
                        src_d = i_halt_bit ? src_q : SRC_NONE;
                    end
                end else if (!i_halt_bit) begin
                    state_d = ST_OP_EN;
                    src_d = SRC_NONE;
                end
            end
            ST_QS_DECEL: begin
                if (i_at_standstill) begin
                    state_d = opt_keeps_servo ? ST_QS_ACTIVE
                        : ST_SW_ON_DIS; // see RULE1 see RULE3 see RULE4 see RULE5
                    src_d = opt_keeps_servo ? src_q : SRC_NONE;
                end
            end
            ST_QS_ACTIVE: begin
                // Releasing here relies on the controller's position follow-up in csp
                if (!i_enable_cmd) begin
                    state_d = ST_SW_ON_DIS;
                    src_d = SRC_NONE;
                end else if (!i_qs_cmd) begin
                    state_d = ST_OP_EN; // see RULE6 see RULE7
                    src_d = SRC_NONE;
                end
            end
            default: begin
                state_d = ST_SW_ON_DIS;
                src_d = SRC_NONE;
            end
        endcase
    end

    // Brake stays on until the drive is enabled again
    assign brake_d = (state_d == ST_SW_ON_DIS)
        && (qs_brake_entry || (brake_q && state_q == ST_SW_ON_DIS)); // see RULE2

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            state_q <= ST_SW_ON_DIS;
            src_q <= SRC_NONE;
            servo_q <= 1'b0;
            brake_q <= 1'b0;
            tzero_q <= 1'b0;
            rej_q <= 1'b0;
        end else begin
            state_q <= state_d;
            src_q <= src_d;
            servo_q <= (state_d != ST_SW_ON_DIS);
            brake_q <= brake_d;
            tzero_q <= (src_d == SRC_TORQUE_SLOPE); // see RULE11
            rej_q <= qs_rej || halt_rej;
        end
    end

    assign o_state = state_q;
    assign o_servo_on = servo_q;
    assign o_dyn_brake = brake_q;
    assign o_decel_src = src_q;
    assign o_torque_zero = tzero_q;
    assign o_qs_opt = qs_opt;
    assign o_halt_opt = halt_opt;
    assign o_opt_reject = rej_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    property p_qs6_hold;
        @(posedge i_clk) disable iff (i_sys_rst)
        (state_q == ST_QS_DECEL && qs_opt == OPT_W'(`QS_OPT_RAMP_QS_HOLD) && i_at_standstill)
        |=> (o_state == ST_QS_ACTIVE && o_servo_on && o_decel_src == SRC_QS_DECEL);
    endproperty
    a_qs6_hold: assert property (p_qs6_hold) else $error("option 6 did not hold"); // see RULE1

    property p_torque_brake;
        @(posedge i_clk) disable iff (i_sys_rst)
        (state_q == ST_OP_EN && i_enable_cmd && i_qs_cmd && torque_mode)
        |=> (o_state == ST_SW_ON_DIS && !o_servo_on && o_dyn_brake);
    endproperty
    a_torque_brake: assert property (p_torque_brake) else $error("no brake stop"); // see RULE2

    property p_qs1_disable;
        @(posedge i_clk) disable iff (i_sys_rst)
        (state_q == ST_QS_DECEL && qs_opt == OPT_W'(`QS_OPT_RAMP_MODE_DIS) && i_at_standstill)
        |=> (o_state == ST_SW_ON_DIS && !o_servo_on && !o_dyn_brake);
    endproperty
    a_qs1_disable: assert property (p_qs1_disable) else $error("option 1 end wrong"); // see RULE3

    property p_qs2_source;
        @(posedge i_clk) disable iff (i_sys_rst)
        (state_q == ST_OP_EN && i_enable_cmd && i_qs_cmd && !torque_mode
            && qs_opt == OPT_W'(`QS_OPT_RAMP_QS_DIS))
        |=> (o_state == ST_QS_DECEL && o_decel_src == SRC_QS_DECEL);
    endproperty
    a_qs2_source: assert property (p_qs2_source) else $error("option 2 ramp wrong"); // see RULE4

    property p_qs5_hold;
        @(posedge i_clk) disable iff (i_sys_rst)
        (state_q == ST_QS_DECEL && qs_opt == OPT_W'(`QS_OPT_RAMP_MODE_HOLD) && i_at_standstill)
        |=> (o_state == ST_QS_ACTIVE && o_servo_on);
    endproperty
    a_qs5_hold: assert property (p_qs5_hold) else $error("option 5 did not hold"); // see RULE5

    property p_halt_start;
        @(posedge i_clk) disable iff (i_sys_rst)
        (state_q == ST_OP_EN && i_enable_cmd && !i_qs_cmd && i_halt_bit && halt_mode)
        |=> (o_state == ST_HALT_DECEL && o_servo_on && o_decel_src != SRC_NONE
            && o_decel_src != SRC_QS_DECEL);
    endproperty
    a_halt_start: assert property (p_halt_start) else $error("halt ramp wrong"); // see RULE8

    property p_halt_resume;
        @(posedge i_clk) disable iff (i_sys_rst)
        (state_q == ST_HALT_DECEL && i_enable_cmd && !i_qs_cmd && !i_halt_bit
            && i_at_standstill)
        |=> (o_state == ST_OP_EN && o_decel_src == SRC_NONE);
    endproperty
    a_halt_resume: assert property (p_halt_resume) else $error("halt did not resume"); // see RULE9

    property p_halt_ignored;
        @(posedge i_clk) disable iff (i_sys_rst)
        (state_q == ST_OP_EN && i_enable_cmd && !i_qs_cmd && !halt_mode)
        |=> (o_state == ST_OP_EN);
    endproperty
    a_halt_ignored: assert property (p_halt_ignored) else $error("halt acted"); // see RULE10

    property p_tq_zero;
        @(posedge i_clk) disable iff (i_sys_rst)
        (state_q == ST_OP_EN && i_enable_cmd && !i_qs_cmd && i_halt_bit && i_mode == MODE_TQ)
        |=> (o_torque_zero && o_decel_src == SRC_TORQUE_SLOPE);
    endproperty
    a_tq_zero: assert property (p_tq_zero) else $error("tq halt not zeroed"); // see RULE11 RULE12

    property p_pt_halt;
        @(posedge i_clk) disable iff (i_sys_rst)
        (state_q == ST_OP_EN && i_enable_cmd && !i_qs_cmd && i_halt_bit
            && i_mode == MODE_POINT_TABLE)
        |=> (o_decel_src == SRC_POINT_TABLE_DECEL);
    endproperty
    a_pt_halt: assert property (p_pt_halt) else $error("pt halt ramp wrong"); // see RULE13

    property p_opt_refuse;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_qs_opt_wr && !qs_opt_ok) |=> (o_qs_opt == $past(o_qs_opt)) ##1 o_opt_reject;
    endproperty
    a_opt_refuse: assert property (p_opt_refuse) else $error("bad option taken"); // see RULE14
endmodule
`default_nettype wire

// [motion_ctrl_model.sv]
// Motion controller model driving the sequencer's command inputs
`timescale 1ns/1ps
`default_nettype none
module motion_ctrl_model (
    input wire logic i_clk, // System clock
    input wire logic i_sys_rst, // Synchronous reset
    input wire qsh_pkg::ctrl_mode_t i_mode_req, // Requested mode
    input wire logic i_en_req, // Requested enable
    input wire logic i_qs_req, // Requested quick stop
    input wire logic i_halt_req, // Requested halt
    input wire logic i_follow_up, // Controller can follow position
    input wire logic [7:0] i_stop_len, // Cycles to standstill
    input wire logic i_qs_wr_req, // Requested option write
    input wire logic [15:0] i_qs_val_req, // Requested option value
    input wire qsh_pkg::drive_state_t i_state, // Drive state
    output qsh_pkg::ctrl_mode_t o_mode, // Control mode
    output logic o_enable_cmd, // Enable operation
    output logic o_qs_cmd, // Quick stop level
    output logic o_halt_bit, // Halt bit
    output logic o_at_standstill, // Motor stopped
    output logic o_qs_opt_wr, // Option write strobe
    output logic [15:0] o_qs_opt_val // Option write value
);
    import qsh_pkg::*;
    logic [7:0] cnt_q;
    logic ss_q;
    wire stopping = (i_state == ST_QS_DECEL) || (i_state == ST_HALT_DECEL);
    // Cancelling here would make the motor lurch without position follow-up
    wire csp_hold = (i_mode_req == MODE_CSP) && (i_state == ST_QS_ACTIVE) && !i_follow_up;
    wire keep_opt = (i_qs_val_req == 16'h0005) || (i_qs_val_req == 16'h0006);
    assign o_qs_opt_wr = i_qs_wr_req && !(keep_opt && !i_follow_up);
    assign o_qs_opt_val = i_qs_val_req;
    assign o_mode = i_mode_req;
    assign o_enable_cmd = i_en_req;
    assign o_halt_bit = i_halt_req;
    assign o_qs_cmd = i_qs_req || csp_hold;
    assign o_at_standstill = ss_q;
    // Standstill drops once no stop runs, so no stale level lingers
    always_ff @(negedge i_clk) begin
        if (i_sys_rst || !stopping) begin
            cnt_q <= 8'h00;
            ss_q <= 1'b0;
        end else begin
            if (cnt_q != 8'hFF) cnt_q <= cnt_q + 8'h01;
            ss_q <= (cnt_q >= i_stop_len);
        end
    end
endmodule
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the quick stop and halt sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import qsh_pkg::*;
    logic clk = 0, rst = 1, en_r = 0, qs_r = 0, hl_r = 0, fu = 1, qwr = 0, hwr = 0;
    ctrl_mode_t md = MODE_PP;
    logic [7:0] sl = 8'h00;
    logic [15:0] qv = 16'h0000, hv = 16'h0000, lf = 16'h0055;
    ctrl_mode_t mode;
    logic en, qs, halt, ss, qw, servo, brk, tz, rej;
    logic [15:0] qval, qo, ho;
    drive_state_t state;
    decel_src_t src;
    int mismatches = 0, num_checks = 0, cyc = 0, st, es, eb, eo, eh, ql, ex;
    int rq[$] = {0, 0};
    int opts[4] = '{1, 2, 5, 6};
    int bad[5] = '{0, 3, 4, 7, 8};
    bit started = 0;
    motion_ctrl_model i_motion_ctrl_model (.i_clk(clk), .i_sys_rst(rst), .i_mode_req(md),
        .i_en_req(en_r), .i_qs_req(qs_r), .i_halt_req(hl_r), .i_follow_up(fu),
        .i_stop_len(sl), .i_qs_wr_req(qwr), .i_qs_val_req(qv), .i_state(state), .o_mode(mode),
        .o_enable_cmd(en), .o_qs_cmd(qs), .o_halt_bit(halt), .o_at_standstill(ss),
        .o_qs_opt_wr(qw), .o_qs_opt_val(qval));
    quick_stop_halt_sequencer i_quick_stop_halt_sequencer (.i_clk(clk), .i_sys_rst(rst),
        .i_mode(mode), .i_enable_cmd(en), .i_qs_cmd(qs), .i_halt_bit(halt),
        .i_at_standstill(ss), .i_qs_opt_wr(qw), .i_qs_opt_val(qval), .i_halt_opt_wr(hwr),
        .i_halt_opt_val(hv), .o_state(state), .o_servo_on(servo), .o_dyn_brake(brk),
        .o_decel_src(src), .o_torque_zero(tz), .o_qs_opt(qo), .o_halt_opt(ho),
        .o_opt_reject(rej));
    `define CMP(a, b) chk(16'(a), 16'(b))
    always #10 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] a, input logic [15:0] b);
        num_checks++;
        if (a !== b) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, a, b);
        end
    endtask
    task automatic print_verdict;
        $display("Checks %0d, mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic go(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic drive(input ctrl_mode_t m, input logic e, q, h, input logic [7:0] s);
        md <= m;
        en_r <= e;
        qs_r <= q;
        hl_r <= h;
        sl <= s;
    endtask
    task automatic wr_opt(input logic [15:0] q, h);
        @(negedge clk);
        qwr <= 1'b1;
        qv <= q;
        hwr <= 1'b1;
        hv <= h;
        @(negedge clk);
        qwr <= 1'b0;
        hwr <= 1'b0;
    endtask
    function automatic logic [15:0] nxt(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function automatic int qsrc(int o, int m);
        if (o == 2 || o == 6) return 1;
        if (m inside {1, 2, 9}) return 2;
        if (m == 4) return 3;
        if (m == 8) return 4;
        return 1;
    endfunction
    function automatic int hsrc(int m);
        if (m == 3) return 5;
        if (m == 4) return 3;
        if (m == 8) return 4;
        return 2;
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    // Reference model; the option code is latched at quick stop entry
    always @(posedge clk) begin : ref_model
        int m;
        m = int'(mode);
        cyc++;
        if (rst) begin
            {st, es, eb, eo, eh, ql} = {32'd1, 32'd0, 32'd0, 32'd2, 32'd1, 32'd2};
            rq = {0, 0};
        end else begin
            // Refusal shows two edges after the write: a two-deep queue
            rq.push_back(int'((qw && !(qval inside {1, 2, 5, 6})) || (hwr && hv != 1)));
            void'(rq.pop_front());
            if (st == 1) begin
                if (en && !qs) {st, eb} = {32'd2, 32'd0};
            end else if (st == 4) begin
                if (ss) {st, es} = (ql < 3) ? {32'd1, 32'd0} : {32'd8, es};
            end else if (st == 8) begin
                if (!en) {st, es} = {32'd1, 32'd0};
                else if (!qs) {st, es} = {32'd2, 32'd0};
            end else if (!en) {st, es} = {32'd1, 32'd0};
            else if (qs && m inside {3, 7, 10}) {st, es, eb} = {32'd1, 32'd0, 32'd1};
            else if (qs) {st, es, ql} = {32'd4, qsrc(eo, m), eo};
            else if (st == 2) begin
                if (halt && m inside {1, 2, 3, 4, 8, 9}) {st, es} = {32'd16, hsrc(m)};
            end else if (st == 16 && ss) {st, es} = halt ? {32'd32, es} : {32'd2, 32'd0};
            else if (st == 32 && !halt) {st, es} = {32'd2, 32'd0};
            if (qw && qval inside {1, 2, 5, 6}) eo = int'(qval);
        end
        started = 1;
        if (cyc == 20000) begin
            mismatches++;
            print_verdict();
        end
    end
    always @(negedge clk) begin
        if (started) begin
            `CMP(state, st);
            `CMP(servo, st != 1);
            `CMP(brk, eb);
            `CMP(src, es);
            `CMP(tz, es == 5);
            `CMP(qo, eo);
            `CMP(ho, eh);
            `CMP(rej, rq[0]);
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(negedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            for (int m = 1; m <= 10; m++) begin
                wr_opt(16'(opts[i]), 16'h0001);
                drive(ctrl_mode_t'(m), 1'b1, 1'b0, 1'b0, 8'(m));
                go(3);
                drive(ctrl_mode_t'(m), 1'b1, 1'b1, 1'b0, 8'(m));
                go(14);
                ex = (m inside {3, 7, 10} || i < 2) ? 1 : 8;
                `CMP(state, ex);
                drive(ctrl_mode_t'(m), 1'b1, 1'b0, 1'b0, 8'(m));
                go(3);
            end
        end
        for (int v = 0; v < 2; v++) begin
            for (int m = 1; m <= 10; m++) begin
                drive(ctrl_mode_t'(m), 1'b1, 1'b0, 1'b1, 8'd6);
                go(2);
                `CMP(tz, m == 3);
                ex = (m inside {1, 2, 3, 4, 8, 9}) ? 16 : 2;
                `CMP(state, ex);
                drive(ctrl_mode_t'(m), 1'b1, 1'b0, 1'(v), 8'd6);
                go(12);
                `CMP(state, (v == 1 && ex == 16) ? 32 : 2);
                drive(ctrl_mode_t'(m), 1'b1, 1'b0, 1'b0, 8'd6);
                go(3);
            end
        end
        foreach (bad[j]) begin
            wr_opt(16'(bad[j]), 16'h0002);
            `CMP(qo, 16'h0006);
        end
        // Random traffic; quick stop option writes only in states 1 and 2 so the latched option is unambiguous
        for (int k = 0; k < 3000; k++) begin
            @(negedge clk);
            lf = nxt(lf);
            if (k % 8 == 0) begin
                md <= ctrl_mode_t'(4'(lf[3:0] % 4'hA + 4'h1));
                sl <= {4'h0, lf[7:4]};
                fu <= lf[8];
            end
            qs_r <= lf[12] & lf[13];
            // Enable may drop in quick stop active; a running quick stop ramp is never cut, a halt ramp can be
            en_r <= (st == 4) || (|lf[11:9]);
            hl_r <= lf[14];
            qwr <= (st <= 2) && !(lf[12] & lf[13]) && lf[15] && lf[0];
            qv <= {12'h000, lf[3:0]};
            hwr <= lf[2] & lf[5];
            hv <= {14'h0000, lf[7:6]};
        end
        print_verdict();
    end
endmodule
`default_nettype wire
